// ===== fmtcl_top.sv
`timescale 1ns/1ps
// Function
// R1: Divider setting held as fourteen-bit word
// R2: Host computes divider word, truncating down
// R3: Divider write starts search or preset
// R4: Any of six byte writes retriggers synthesizer; code ignores writes in standby
// R5: Lock flag set after confirmation, 2-10 ms
// R6: Band bit picks 87.5-108 or 76-90 MHz
// R7: IF count runs continuously, seven bits readable
// R8: IF flag when count outside valid window
// R9: Count-time bit picks 2 or 15.6 ms
// R10: Level digitized continuously to four bits
// R11: Low-level flag with selectable hysteresis
// R12: Threshold 3 during search, 0 once tuned; code drops 3 to 0 with large hysteresis, to 2 with small
// R13: Control bit disables soft attenuation
// R14: Hard mutes tristate outputs, force mono; standby
// R15: Audio mute blocks signal, outputs stay biased
// R16: Automatic mute during alternative-frequency update
// R17: Clearing audio mute halts RDS delivery
// R18: Mono, blend mode and noise cancel controls
// R19: Port shows ready, host bit or test
// R20: Power bits switch RDS or both off
// R21: RDS flags defaulted 0.9 ms after power-up
// R22: Data-available flag and interrupt announce RDS
// R23: Host picks search or preset via bit
module fmtcl_top #(
  parameter int LOCK_MIN  = fmtcl_pkg::LOCK_MIN_CYC,
  parameter int LOCK_MAX  = fmtcl_pkg::LOCK_MAX_CYC,
  parameter int IFC_SHORT = fmtcl_pkg::IFC_SHORT_CYC,
  parameter int IFC_LONG  = fmtcl_pkg::IFC_LONG_CYC,
  parameter int RDS_INIT  = fmtcl_pkg::RDS_INIT_CYC,
  parameter logic [6:0] IF_WIN_LO = 7'h1e,
  parameter logic [6:0] IF_WIN_HI = 7'h3e
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ref_clk,
  input  wire fmtcl_pkg::fmtcl_ctrl_t ctrl,
  input  wire logic [13:0]            freq_word,
  input  wire logic [5:0]             byte_write,
  input  wire logic                   synth_lock_in,
  input  wire fmtcl_pkg::fmtcl_meas_t meas_in,
  input  wire logic                   meas_strobe,
  input  wire logic                   test_signal,
  input  wire logic                   rds_new_data,
  input  wire logic                   rds_read_ack,
  output logic [13:0]                 synth_word,
  output logic                        synth_retrigger,
  output logic                        synth_lock_flag,
  output logic                        tune_ready_flag,
  output logic                        if_flag,
  output logic                        low_level_flag,
  output logic                        band_limit_flag,
  output logic                        if_period_short,
  output fmtcl_pkg::fmtcl_meas_t      meas_out,
  output fmtcl_pkg::fmtcl_audio_t     audio,
  output logic                        fm_enable,
  output logic                        rds_enable,
  output logic                        rds_deliver_enable,
  output logic                        rds_flags_clear,
  output logic                        rds_data_avail_flag,
  output logic                        interrupt_out_n,
  output logic                        programmable_out_pin
);
  import fmtcl_pkg::*;

  initial begin
    if (LOCK_MIN < 1 || LOCK_MAX < LOCK_MIN || IFC_SHORT < 1 || IFC_LONG < IFC_SHORT ||
        RDS_INIT < 2 || IFC_LONG >= (1 << 20) || LOCK_MAX >= (1 << 20) ||
        RDS_INIT >= (1 << 20) || IF_WIN_LO > IF_WIN_HI) begin
      $error("fmtcl_top: timing or window parameters out of range");
    end
  end

  localparam logic [19:0] LOCK_MIN_L  = 20'(LOCK_MIN - 1);
  localparam logic [19:0] LOCK_MAX_L  = 20'(LOCK_MAX - 1);
  localparam logic [19:0] IFC_SHORT_L = 20'(IFC_SHORT - 1);
  localparam logic [19:0] IFC_LONG_L  = 20'(IFC_LONG - 1);
  localparam logic [19:0] RDS_INIT_L  = 20'(RDS_INIT);

  // Link side: analogue measurements on the reference clock
  typedef struct packed {
    logic        req;
    logic        ack_s1;
    logic        ack_s2;
    fmtcl_meas_t word;
  } fmtcl_link_t;

  typedef struct packed {
    fmtcl_state_t st;
    logic [19:0]  timer;
    logic [13:0]  freq;
    logic [13:0]  home_freq;
    logic         retrig;
    logic         is_search;
    logic         af_update;
    logic         short_count;
    logic         tuned;
    logic         lock;
    logic         ready;
    logic         band_flag;
    logic         if_fl;
    logic         lvl_fl;
    fmtcl_meas_t  meas;
    logic         lock_s1;
    logic         lock_s2;
    logic         req_s1;
    logic         req_s2;
    logic         ack;
    logic         rds_on_prev;
    logic [19:0]  rds_timer;
    logic         rds_clear;
    logic         rds_avail;
    fmtcl_audio_t aud;
    logic         fm_en;
    logic         rds_en;
    logic         rds_deliver;
    logic         port;
    logic         intr_n;
  } fmtcl_main_t;

  fmtcl_link_t lk_q, lk_d;
  fmtcl_main_t m_q, m_d;

  // The word is only reloaded once the previous one was acknowledged, so it
  // is stable for the whole time the main domain may sample it.
  always_comb begin
    lk_d        = lk_q;
    lk_d.ack_s1 = m_q.ack;
    lk_d.ack_s2 = lk_q.ack_s1;
    if (meas_strobe && (lk_q.req == lk_q.ack_s2)) begin
      lk_d.word = meas_in;                                           // see R7, R10
      lk_d.req  = ~lk_q.req;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  logic        fm_on;
  logic        rds_on;
  logic [3:0]  thr;
  logic [3:0]  hyst;
  logic [3:0]  thr_eff;
  logic [13:0] band_lo;
  logic [13:0] band_hi;
  logic        good;
  logic        at_limit;

  always_comb begin
    fm_on   = ctrl.power_control_bits != PWR_STANDBY;                // see R20
    rds_on  = ctrl.power_control_bits == PWR_ALL_ON;
    thr     = (ctrl.level_threshold < LEVEL_THR_MIN) ? LEVEL_THR_MIN : ctrl.level_threshold;
    hyst    = ctrl.level_hysteresis_select ? HYST_LARGE : HYST_SMALL; // see R11
    // Once tuned, hysteresis lowers the limit; from 3 it reaches 0 with the large hysteresis, 2 with the small
    if (m_q.tuned) begin
      thr_eff = (thr > hyst) ? 4'(thr - hyst) : 4'h0;                // see R12
    end else begin
      thr_eff = thr;
    end
    band_lo = ctrl.band_select ? BAND_JP_LO : BAND_EU_LO;            // see R6
    band_hi = ctrl.band_select ? BAND_JP_HI : BAND_EU_HI;
    good    = m_q.lock && !m_q.if_fl && (m_q.meas.level >= thr_eff);
    if (ctrl.search_up) begin
      at_limit = (m_q.freq >= band_hi) || (band_hi - m_q.freq < SEARCH_STEP);
    end else begin
      at_limit = (m_q.freq <= band_lo) || (m_q.freq - band_lo < SEARCH_STEP);
    end
  end

  always_comb begin
    m_d         = m_q;
    m_d.retrig  = 1'b0;
    m_d.rds_clear = 1'b0;

    m_d.lock_s1 = synth_lock_in;
    m_d.lock_s2 = m_q.lock_s1;
    m_d.req_s1  = lk_q.req;
    m_d.req_s2  = m_q.req_s1;
    if (m_q.req_s2 != m_q.ack) begin
      m_d.meas = lk_q.word;                                          // see R7, R10
      m_d.ack  = m_q.req_s2;
    end
    m_d.if_fl  = (m_q.meas.if_count < IF_WIN_LO) ||
                 (m_q.meas.if_count > IF_WIN_HI);                    // see R8
    m_d.lvl_fl = m_q.meas.level < thr_eff;                          // see R11, R12

    unique case (m_q.st)
      FMTCL_IDLE: begin
      end
      FMTCL_SETTLE: begin
        m_d.timer = m_q.timer + 20'h00001;
        if (m_q.timer >= LOCK_MIN_L && m_q.lock_s2) begin
          m_d.lock  = 1'b1;                                          // see R5
          m_d.st    = FMTCL_COUNT;
          m_d.timer = '0;
        end else if (m_q.timer >= LOCK_MAX_L) begin
          m_d.st    = FMTCL_COUNT;
          m_d.timer = '0;
        end
      end
      FMTCL_COUNT: begin
        m_d.timer = m_q.timer + 20'h00001;
        if (m_q.timer >= (m_q.short_count ? IFC_SHORT_L : IFC_LONG_L)) begin // see R9
          m_d.timer = '0;
          m_d.st    = FMTCL_DONE;
          if (m_q.is_search && !good) begin                          // see R3
            if (at_limit) begin
              m_d.band_flag = 1'b1;
            end else begin
              m_d.freq   = ctrl.search_up ? m_q.freq + SEARCH_STEP : m_q.freq - SEARCH_STEP;
              m_d.retrig = 1'b1;
              m_d.lock   = 1'b0;
              m_d.st     = FMTCL_SETTLE;
            end
          end else if (m_q.af_update && !good) begin
            // Failed alternative frequency: return to where we came from
            m_d.freq        = m_q.home_freq;
            m_d.af_update   = 1'b0;
            m_d.short_count = 1'b0;
            m_d.retrig      = 1'b1;
            m_d.lock        = 1'b0;
            m_d.st          = FMTCL_SETTLE;
          end
        end
      end
      FMTCL_DONE: begin
        m_d.ready       = 1'b1;
        m_d.tuned       = 1'b1;
        m_d.af_update   = 1'b0;
        m_d.short_count = 1'b0;                                      // see R9
        m_d.st          = FMTCL_IDLE;
      end
      default: begin
        m_d.st = FMTCL_IDLE;
      end
    endcase

    // Outside standby a new write wins over whatever tuning was under way
    if ((|byte_write) && fm_on) begin                                // see R4
      m_d.home_freq   = m_q.freq;
      m_d.freq        = freq_word;                                   // see R1
      m_d.retrig      = 1'b1;
      m_d.is_search   = ctrl.search_mode_bit;                        // see R3, R23
      m_d.af_update   = !ctrl.search_mode_bit && ctrl.if_count_time_select; // see R9
      m_d.short_count = ctrl.if_count_time_select;
      m_d.tuned       = 1'b0;
      m_d.lock        = 1'b0;
      m_d.ready       = 1'b0;
      m_d.band_flag   = 1'b0;
      m_d.timer       = '0;
      m_d.st          = FMTCL_SETTLE;
    end else if (!fm_on) begin
      // Standby halts tuning but keeps the host-visible word
      m_d.st     = FMTCL_IDLE;
      m_d.retrig = 1'b0;                                             // see R20
      m_d.timer = '0;
      m_d.lock  = 1'b0;
    end

    // RDS section start-up after the power bits turn it on
    m_d.rds_on_prev = rds_on;
    if (rds_on && !m_q.rds_on_prev) begin
      m_d.rds_timer = RDS_INIT_L;
    end else if (!rds_on) begin
      m_d.rds_timer = '0;
    end else if (m_q.rds_timer != '0) begin
      m_d.rds_timer = m_q.rds_timer - 20'h00001;
      if (m_q.rds_timer == 20'h00001) begin
        m_d.rds_clear = 1'b1;                                        // see R21
      end
    end

    // Held off on the power-up edge, before the start-up timer has loaded
    m_d.rds_deliver = rds_on && m_q.rds_on_prev && ctrl.audio_freq_mute &&
                      (m_q.rds_timer == '0);                         // see R17
    // Set wins over the host's acknowledge in the same cycle
    if (m_q.rds_clear) begin
      m_d.rds_avail = 1'b0;                                          // see R21
    end else if (rds_new_data && m_q.rds_deliver) begin
      m_d.rds_avail = 1'b1;                                          // see R22
    end else if (rds_read_ack) begin
      m_d.rds_avail = 1'b0;
    end
    m_d.intr_n = !m_d.rds_avail;                                     // see R22

    m_d.fm_en  = fm_on;                                              // see R20
    m_d.rds_en = rds_on;

    // Hard mute tristates; a one-sided mute also forces mono
    m_d.aud.audio_out_left_en  = fm_on && !ctrl.hard_mute_both && !ctrl.hard_mute_left;  // see R14
    m_d.aud.audio_out_right_en = fm_on && !ctrl.hard_mute_both && !ctrl.hard_mute_right; // see R14
    m_d.aud.mono = ctrl.force_mono || ctrl.hard_mute_left || ctrl.hard_mute_right;       // see R14, R18
    m_d.aud.af_block = ctrl.audio_freq_mute || m_d.af_update;        // see R15, R16
    m_d.aud.soft_atten_on  = ctrl.soft_atten_enable;                 // see R13
    m_d.aud.blend_switched = ctrl.blend_switched;                    // see R18
    m_d.aud.snc_on         = ctrl.stereo_noise_cancel;               // see R18

    // Port is not gated by standby
    if (ctrl.test_mode_bit) begin
      m_d.port = test_signal;                                        // see R19
    end else if (ctrl.port_mode_select) begin
      m_d.port = m_d.ready;                                          // see R19
    end else begin
      m_d.port = ctrl.port_value_bit;                                // see R19
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q        <= '0;
      m_q.st     <= FMTCL_IDLE;
      m_q.freq   <= FREQ_RESET;
      m_q.meas   <= '{if_count: IFCNT_RESET, level: LEVEL_RESET};
      m_q.intr_n <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  assign synth_word           = m_q.freq;
  assign synth_retrigger      = m_q.retrig;
  assign synth_lock_flag      = m_q.lock;
  assign tune_ready_flag      = m_q.ready;
  assign if_flag              = m_q.if_fl;
  assign low_level_flag       = m_q.lvl_fl;
  assign band_limit_flag      = m_q.band_flag;
  assign if_period_short      = m_q.short_count;
  assign meas_out             = m_q.meas;
  assign audio                = m_q.aud;
  assign fm_enable            = m_q.fm_en;
  assign rds_enable           = m_q.rds_en;
  assign rds_deliver_enable   = m_q.rds_deliver;
  assign rds_flags_clear      = m_q.rds_clear;
  assign rds_data_avail_flag  = m_q.rds_avail;
  assign interrupt_out_n      = m_q.intr_n;
  assign programmable_out_pin = m_q.port;

endmodule : fmtcl_top

// ===== fmtcl_pkg.sv
package fmtcl_pkg;

  // Reference and link timing
  localparam longint REF_HZ        = 64'd32768;
  localparam longint IF_HZ         = 64'd225000;
  localparam longint CLK_HZ        = 64'd20000000;
  localparam longint CLK_PERIOD_NS = 64'd1000000000 / CLK_HZ;

  // Times as printed, in nanoseconds
  localparam longint LOCK_MIN_NS   = 64'd2000000;
  localparam longint LOCK_MAX_NS   = 64'd10000000;
  localparam longint IFC_SHORT_NS  = 64'd2000000;
  localparam longint IFC_LONG_NS   = 64'd15600000;
  localparam longint RDS_INIT_NS   = 64'd900000;

  // Least times and count times round up, the lock maximum rounds down
  localparam int LOCK_MIN_CYC  = int'((LOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int LOCK_MAX_CYC  = int'(LOCK_MAX_NS / CLK_PERIOD_NS);
  localparam int IFC_SHORT_CYC = int'((IFC_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int IFC_LONG_CYC  = int'((IFC_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int RDS_INIT_CYC  = int'((RDS_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Band edges in Hz and as high-side divider words, truncated
  localparam longint BAND_EU_LO_HZ = 64'd87500000;
  localparam longint BAND_EU_HI_HZ = 64'd108000000;
  localparam longint BAND_JP_LO_HZ = 64'd76000000;
  localparam longint BAND_JP_HI_HZ = 64'd90000000;
  localparam longint RASTER_HZ     = 64'd100000;
  localparam logic [13:0] BAND_EU_LO = 14'((64'd4 * (BAND_EU_LO_HZ + IF_HZ)) / REF_HZ);
  localparam logic [13:0] BAND_EU_HI = 14'((64'd4 * (BAND_EU_HI_HZ + IF_HZ)) / REF_HZ);
  localparam logic [13:0] BAND_JP_LO = 14'((64'd4 * (BAND_JP_LO_HZ + IF_HZ)) / REF_HZ);
  localparam logic [13:0] BAND_JP_HI = 14'((64'd4 * (BAND_JP_HI_HZ + IF_HZ)) / REF_HZ);
  localparam logic [13:0] SEARCH_STEP = 14'((64'd4 * RASTER_HZ) / REF_HZ);

  // Level comparison
  localparam logic [3:0] LEVEL_THR_MIN = 4'h3;
  localparam logic [3:0] HYST_LARGE    = 4'h3;
  localparam logic [3:0] HYST_SMALL    = 4'h1;

  // Power control encodings
  localparam logic [1:0] PWR_STANDBY = 2'h0;
  localparam logic [1:0] PWR_FM_ONLY = 2'h1;
  localparam logic [1:0] PWR_ALL_ON  = 2'h3;

  // Reset values
  localparam logic [13:0] FREQ_RESET  = 14'h0000;
  localparam logic [6:0]  IFCNT_RESET = 7'h00;
  localparam logic [3:0]  LEVEL_RESET = 4'h0;

  typedef enum logic [2:0] {
    FMTCL_IDLE   = 3'b000,
    FMTCL_SETTLE = 3'b001,
    FMTCL_COUNT  = 3'b010,
    FMTCL_DONE   = 3'b011
  } fmtcl_state_t;

  typedef struct packed {
    logic       search_mode_bit;
    logic       search_up;
    logic       band_select;
    logic       if_count_time_select;
    logic       level_hysteresis_select;
    logic [3:0] level_threshold;
    logic       soft_atten_enable;
    logic       hard_mute_both;
    logic       hard_mute_left;
    logic       hard_mute_right;
    logic       audio_freq_mute;
    logic       force_mono;
    logic       blend_switched;
    logic       stereo_noise_cancel;
    logic       port_mode_select;
    logic       port_value_bit;
    logic       test_mode_bit;
    logic [1:0] power_control_bits;
  } fmtcl_ctrl_t;

  typedef struct packed {
    logic [6:0] if_count;
    logic [3:0] level;
  } fmtcl_meas_t;

  typedef struct packed {
    logic audio_out_left_en;
    logic audio_out_right_en;
    logic af_block;
    logic soft_atten_on;
    logic mono;
    logic blend_switched;
    logic snc_on;
  } fmtcl_audio_t;

endpackage : fmtcl_pkg

// ===== fmtcl_properties.sv
`timescale 1ns/1ps
module fmtcl_properties (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire fmtcl_pkg::fmtcl_ctrl_t ctrl,
  input wire logic [13:0]            freq_word,
  input wire logic [5:0]             byte_write,
  input wire logic                   rds_new_data,
  input wire logic                   rds_read_ack,
  input wire logic [13:0]            synth_word,
  input wire logic                   synth_retrigger,
  input wire logic                   synth_lock_flag,
  input wire logic                   tune_ready_flag,
  input wire fmtcl_pkg::fmtcl_audio_t audio,
  input wire logic                   rds_deliver_enable,
  input wire logic                   rds_data_avail_flag,
  input wire logic                   interrupt_out_n,
  input wire logic                   programmable_out_pin
);
  import fmtcl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_on;
    |byte_write && ctrl.power_control_bits != PWR_STANDBY;
  endsequence
  // Port mode held two cycles with a steady ready flag
  sequence s_port_ready;
    !ctrl.test_mode_bit && ctrl.port_mode_select
    ##1 !ctrl.test_mode_bit && ctrl.port_mode_select && $stable(tune_ready_flag);
  endsequence

  chk_retrig_write: assert property (s_write_on |=> synth_retrigger)
    else $error("no retrigger after byte write");
  chk_word_taken: assert property (s_write_on |=> synth_word == $past(freq_word))
    else $error("divider word not taken");
  chk_standby_refuse: assert property ((|byte_write && ctrl.power_control_bits == PWR_STANDBY)
    |=> !synth_retrigger)
    else $error("write taken in standby");
  chk_retune_clears: assert property (synth_retrigger |-> !tune_ready_flag && !synth_lock_flag)
    else $error("flags not cleared on retune");
  chk_lock_early: assert property (synth_retrigger |=> !synth_lock_flag [*2])
    else $error("lock flag set too early");
  chk_rds_set: assert property (rds_new_data && rds_deliver_enable |=> rds_data_avail_flag)
    else $error("data flag not set");
  chk_rds_ack: assert property (rds_read_ack && !rds_new_data |=> !rds_data_avail_flag)
    else $error("data flag not cleared by ack");
  chk_int_level: assert property (interrupt_out_n == !rds_data_avail_flag)
    else $error("interrupt does not follow data flag");
  chk_mute_both: assert property (ctrl.hard_mute_both || ctrl.power_control_bits == PWR_STANDBY
    |=> !audio.audio_out_left_en && !audio.audio_out_right_en)
    else $error("outputs not hard muted");
  chk_af_block: assert property (ctrl.audio_freq_mute |=> audio.af_block)
    else $error("audio mute not blocking");
  chk_rds_halt: assert property (!ctrl.audio_freq_mute |=> !rds_deliver_enable)
    else $error("rds delivered without audio mute");
  chk_port_ready: assert property (s_port_ready |-> programmable_out_pin == tune_ready_flag)
    else $error("port not showing ready flag");
endmodule : fmtcl_properties

// ===== fmtcl_meas_src.sv
`timescale 1ns/1ps
module fmtcl_meas_src (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire fmtcl_pkg::fmtcl_meas_t sample,
  output fmtcl_pkg::fmtcl_meas_t      meas_in,
  output logic                        meas_strobe
);
  import fmtcl_pkg::*;
  logic [2:0] div_q;
  // Reference runs free; a sample is offered every eighth edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q       <= '0;
      meas_strobe <= 1'b0;
      meas_in     <= '0;
    end else begin
      div_q       <= div_q + 3'h1;
      meas_strobe <= (div_q == 3'h7);
      // Word inverted on each edge after its strobe, so a capture one edge late cannot match
      meas_in     <= (div_q == 3'h7) ? sample : ~meas_in;
    end
  end
endmodule : fmtcl_meas_src

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import fmtcl_pkg::*;
  localparam int         RDS_INIT = 5;
  localparam logic [6:0] WLO      = 7'h1e;
  localparam logic [6:0] WHI      = 7'h3e;
  logic         clk, ref_clk, rst_n, synth_lock_in, meas_strobe, test_signal, rt;
  logic         rds_new_data, rds_read_ack, synth_retrigger, synth_lock_flag, tune_ready_flag;
  logic         if_flag, low_level_flag, fm_enable, rds_deliver_enable, rds_data_avail_flag;
  logic         interrupt_out_n, programmable_out_pin, band_limit_flag, if_period_short, rds_enable;
  logic [13:0]  freq_word, synth_word, w;
  logic [5:0]   byte_write;
  logic [6:0]   ifv;
  fmtcl_ctrl_t  ctrl;
  fmtcl_meas_t  smp, meas_in, meas_out;
  fmtcl_audio_t audio;
  int           fails, tests_run;

  fmtcl_top #(.LOCK_MIN(4), .LOCK_MAX(8), .IFC_SHORT(4), .IFC_LONG(10),
    .RDS_INIT(RDS_INIT), .IF_WIN_LO(WLO), .IF_WIN_HI(WHI)) u_dut (
    .clk, .rst_n, .ref_clk, .ctrl, .freq_word, .byte_write, .synth_lock_in, .meas_in,
    .meas_strobe, .test_signal, .rds_new_data, .rds_read_ack, .synth_word, .synth_retrigger,
    .synth_lock_flag, .tune_ready_flag, .if_flag, .low_level_flag, .band_limit_flag,
    .if_period_short, .meas_out, .audio, .fm_enable, .rds_enable, .rds_deliver_enable,
    .rds_flags_clear(), .rds_data_avail_flag, .interrupt_out_n, .programmable_out_pin);
  fmtcl_meas_src u_src (.ref_clk, .rst_n, .sample(smp), .meas_in, .meas_strobe);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    ref_clk = 1'b0;
    #7;
    forever #40 ref_clk = ~ref_clk;
  end

  task chk(input string n, input logic [13:0] e, input logic [13:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task final_report;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [13:0] v, input int b);
    @(posedge clk);
    freq_word  <= v;
    byte_write <= 6'(1 << b);
    @(posedge clk);
    byte_write <= '0;
    #1 rt = synth_retrigger;
  endtask : wr
  task pulse(input bit ack);
    @(posedge clk);
    if (ack)
      rds_read_ack <= 1'b1;
    else
      rds_new_data <= 1'b1;
    @(posedge clk);
    rds_read_ack <= 1'b0;
    rds_new_data <= 1'b0;
    #1;
  endtask : pulse
  // Bounded wait on ready (0) or rds delivery (1); returns cycles used
  task wait_on(input bit k, output int n);
    for (n = 0; n < 400 && (k ? rds_deliver_enable : tune_ready_flag) !== 1'b1; n++)
      cyc(1);
    if (n == 400) begin
      fails++;
      final_report();
    end
  endtask : wait_on

  task t_tune;
    int n;
    wr(14'h0123, 0);
    chk("retrig_standby", 1'b0, rt);
    @(posedge clk);
    ctrl.power_control_bits <= PWR_FM_ONLY;
    // High-side divider for 100.1 MHz, truncated
    w = 14'((64'd4 * (64'd100100000 + IF_HZ)) / REF_HZ);
    wr(w, 0);
    chk("retrig", 1'b1, rt);
    chk("ready_low", 1'b0, tune_ready_flag);
    wait_on(0, n);
    chk("word", w, synth_word);
    chk("lock", 1'b1, synth_lock_flag);
    for (int b = 0; b < 6; b++) begin
      wr(w + 14'(b), b);
      chk("retrig_byte", 1'b1, rt);
      chk("word_byte", w + 14'(b), synth_word);
    end
    wait_on(0, n);
    $display("test tune done");
  endtask : t_tune

  task t_meas;
    @(posedge clk);
    ctrl.level_threshold <= 4'hf;
    for (int i = 0; i < 4; i++) begin
      ifv = (i == 0) ? WLO - 7'h1 : (i == 1) ? WLO : (i == 2) ? WHI : WHI + 7'h1;
      @(posedge clk);
      smp <= {ifv, 4'(i * 5)};
      cyc(40);
      chk("if_count", 14'(ifv), 14'(meas_out.if_count));
      chk("level", 14'(i * 5), 14'(meas_out.level));
      chk("if_flag", (ifv < WLO || ifv > WHI), if_flag);
      chk("low_flag", (i < 3), low_level_flag);
    end
    $display("test meas done");
  endtask : t_meas

  task t_audio;
    @(posedge clk);
    ctrl.hard_mute_left <= 1'b1;
    cyc(3);
    chk("left_en", 1'b0, audio.audio_out_left_en);
    chk("right_en", 1'b1, audio.audio_out_right_en);
    chk("mono_hm", 1'b1, audio.mono);
    @(posedge clk);
    ctrl.hard_mute_left <= 1'b0;
    ctrl.audio_freq_mute <= 1'b1;
    ctrl.soft_atten_enable <= 1'b1;
    ctrl.blend_switched <= 1'b1;
    ctrl.stereo_noise_cancel <= 1'b1;
    cyc(3);
    chk("af_block", 1'b1, audio.af_block);
    chk("biased", 1'b1, audio.audio_out_left_en);
    chk("soft_on", 1'b1, audio.soft_atten_on);
    chk("blend", 1'b1, audio.blend_switched);
    chk("snc", 1'b1, audio.snc_on);
    @(posedge clk);
    ctrl.audio_freq_mute <= 1'b0;
    ctrl.soft_atten_enable <= 1'b0;
    ctrl.blend_switched <= 1'b0;
    ctrl.stereo_noise_cancel <= 1'b0;
    ctrl.force_mono <= 1'b1;
    ctrl.port_mode_select <= 1'b1;
    cyc(3);
    chk("af_free", 1'b0, audio.af_block);
    chk("soft_off", 1'b0, audio.soft_atten_on);
    chk("snc_off", 1'b0, audio.snc_on);
    chk("mono", 1'b1, audio.mono);
    chk("port_ready", 1'b1, programmable_out_pin);
    $display("test audio done");
  endtask : t_audio

  task t_port;
    @(posedge clk);
    ctrl.power_control_bits <= PWR_STANDBY;
    ctrl.test_mode_bit <= 1'b1;
    test_signal <= 1'b0;
    cyc(3);
    chk("port_test", 1'b0, programmable_out_pin);
    chk("standby_mute", 1'b0, audio.audio_out_right_en);
    @(posedge clk);
    ctrl.test_mode_bit <= 1'b0;
    ctrl.port_mode_select <= 1'b0;
    ctrl.port_value_bit <= 1'b0;
    test_signal <= 1'b1;
    cyc(3);
    chk("port_bit", 1'b0, programmable_out_pin);
    $display("test port done");
  endtask : t_port

  task t_rds;
    int n;
    @(posedge clk);
    ctrl.power_control_bits <= PWR_ALL_ON;
    ctrl.audio_freq_mute <= 1'b1;
    wait_on(1, n);
    chk("startup", 1'b1, n >= RDS_INIT);
    chk("rds_en", 1'b1, rds_enable);
    pulse(0);
    chk("avail", 1'b1, rds_data_avail_flag);
    chk("int_low", 1'b0, interrupt_out_n);
    pulse(1);
    chk("avail_ack", 1'b0, rds_data_avail_flag);
    chk("int_high", 1'b1, interrupt_out_n);
    @(posedge clk);
    ctrl.audio_freq_mute <= 1'b0;
    cyc(3);
    pulse(0);
    chk("deliver_off", 1'b0, rds_deliver_enable);
    chk("avail_off", 1'b0, rds_data_avail_flag);
    $display("test rds done");
  endtask : t_rds

  // Last sample has a bad IF count, so neither search stop nor AF hold
  task t_search;
    int n;
    @(posedge clk);
    ctrl.band_select     <= 1'b1;
    ctrl.search_up       <= 1'b1;
    ctrl.search_mode_bit <= 1'b1;
    wr(BAND_JP_HI - SEARCH_STEP, 0);
    wait_on(0, n);
    chk("band_flag", 1'b1, band_limit_flag);
    chk("search_word", BAND_JP_HI, synth_word);
    @(posedge clk);
    ctrl.search_mode_bit      <= 1'b0;
    ctrl.if_count_time_select <= 1'b1;
    wr(w, 0);
    chk("af_short", 1'b1, if_period_short);
    chk("af_mute", 1'b1, audio.af_block);
    wait_on(0, n);
    chk("af_return", BAND_JP_HI, synth_word);
    chk("af_long", 1'b0, if_period_short);
    $display("test search done");
  endtask : t_search

  initial begin
    {rst_n, synth_lock_in, test_signal, rds_new_data, rds_read_ack} = 5'b01000;
    {ctrl, freq_word, byte_write} = '0;
    smp = {7'h2a, 4'hf};
    fails = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk("int_reset", 1'b1, interrupt_out_n);
    chk("fm_reset", 1'b0, fm_enable);
    chk("mute_reset", 1'b0, audio.audio_out_left_en);
    $display("test reset done");
    t_tune();
    t_meas();
    t_audio();
    t_port();
    t_rds();
    t_search();
    final_report();
  end
endmodule : tb

bind fmtcl_top fmtcl_properties u_chk (
  .clk, .rst_n, .ctrl, .freq_word, .byte_write, .rds_new_data, .rds_read_ack, .synth_word,
  .synth_retrigger, .synth_lock_flag, .tune_ready_flag, .audio, .rds_deliver_enable,
  .rds_data_avail_flag, .interrupt_out_n, .programmable_out_pin);
